// ==== rtl/mmtx_consts.svh ====
// constants of the multi-mode transmit port
`ifndef MMTX_CONSTS_SVH
`define MMTX_CONSTS_SVH

`define MMTX_MCLK_HZ      100000000
`define MMTX_MII_CLK_HZ   25000000
// half period of the generated mii transmit clock, in i_mclk cycles
`define MMTX_MII_HALF     (`MMTX_MCLK_HZ / (2 * `MMTX_MII_CLK_HZ))
`define MMTX_TXD_RST      8'h00
`define MMTX_EN_RST       1'b0
`define MMTX_MASK_GMII    8'hFF
`define MMTX_MASK_MII     8'h0F
`define MMTX_MASK_RMII    8'h03
`define MMTX_BIT8_POS     8

`endif

// ==== rtl/mmtx_pkg.sv ====
// types of the multi-mode transmit port
package mmtx_pkg;

  typedef enum logic [1:0] {
    MMTX_MODE_MII  = 2'h0,
    MMTX_MODE_RMII = 2'h1,
    MMTX_MODE_GMII = 2'h2,
    MMTX_MODE_TBI  = 2'h3
  } mmtx_mode_t;

  typedef enum logic [2:0] {
    MMTX_ST_IDLE = 3'h1,
    MMTX_ST_SEND = 3'h2,
    MMTX_ST_TAIL = 3'h4
  } mmtx_state_t;

  typedef struct packed {
    logic        txc_s1;
    logic        txc_s2;
    logic        txc_s3;
    logic        ref_s1;
    logic        ref_s2;
    logic        ref_s3;
    logic        gtx_s1;
    logic        gtx_s2;
    logic        gtx_s3;
    logic        crs_s1;
    logic        crs_s2;
    logic [1:0]  div;
    logic        gen_clk;
    mmtx_state_t st;
    logic [7:0]  txd;
    logic        txen;
  } mmtx_regs_t;

endpackage

// ==== rtl/mmtx_port.sv ====
// transmit pin logic of one multi-mode mac interface
`timescale 1ns/1ps
`default_nettype none
`include "mmtx_consts.svh"

// Operation
// - transmit clock pin is input in mac role, driven output in phy emulation in mii mode only
// - mii transmit clock is 25 mhz; generated locally in phy emulation
// - data uses lanes 7:0 in gmii/tbi, 3:0 in mii, 1:0 in rmii
// - data launches on rising edge of the mode's selected transmit clock
// - transmit enable rises with first preamble symbol, synchronous to mode clock
// - transmit enable stays high until the frame's last symbol is sent
// - in tbi mode the enable pin carries code-group bit 8
// - carrier sense is input in mac role, output in phy emulation
module mmtx_port (
  input  wire logic               i_mclk,
  input  wire logic               i_rstn,
  input  wire mmtx_pkg::mmtx_mode_t i_mode,
  input  wire logic               i_phy_role,
  input  wire logic               i_tx_clk,
  output logic                    o_tx_clk,
  output logic                    o_tx_clk_oe,
  input  wire logic               i_ref_clk,
  input  wire logic               i_gtx_clk,
  input  wire logic               i_carrier_sense,
  output logic                    o_carrier_sense,
  output logic                    o_carrier_sense_oe,
  output logic                    o_carrier_seen,
  input  wire logic               i_sym_valid,
  input  wire logic [8:0]         i_sym_data,
  input  wire logic               i_sym_last,
  output logic                    o_sym_ready,
  output logic [7:0]              o_txd,
  output logic                    o_tx_en
);
  import mmtx_pkg::*;

  // ==========================================================
  // state
  // every flop of the port lives in this one struct
  mmtx_regs_t r_reg;
  mmtx_regs_t r_next;
  logic       gen_rise;
  logic       mii_edge;
  logic       launch;
  logic       take;
  logic [7:0] lane_mask;

  // ==========================================================
  // edge selection
  always_comb begin
    gen_rise = (r_reg.div == 2'(`MMTX_MII_HALF - 1)) && !r_reg.gen_clk;
    // only the second and third sync stages feed edge detection
    mii_edge = i_phy_role ? gen_rise : (r_reg.txc_s2 && !r_reg.txc_s3);
    case (i_mode)
      MMTX_MODE_MII: begin
        launch    = mii_edge;
        lane_mask = `MMTX_MASK_MII;
      end
      MMTX_MODE_RMII: begin
        launch    = r_reg.ref_s2 && !r_reg.ref_s3;
        lane_mask = `MMTX_MASK_RMII;
      end
      default: begin
        launch    = r_reg.gtx_s2 && !r_reg.gtx_s3;
        lane_mask = `MMTX_MASK_GMII;
      end
    endcase
    // one idle clock is forced between frames so enable visibly drops
    o_sym_ready = launch && (r_reg.st != MMTX_ST_TAIL);
    take        = o_sym_ready && i_sym_valid;
  end

  // ==========================================================
  // next state
  always_comb begin
    r_next        = r_reg;
    // pin clocks: two sync stages, the third stage only finds the edge
    r_next.txc_s1 = i_tx_clk;
    r_next.txc_s2 = r_reg.txc_s1;
    r_next.txc_s3 = r_reg.txc_s2;
    r_next.ref_s1 = i_ref_clk;
    r_next.ref_s2 = r_reg.ref_s1;
    r_next.ref_s3 = r_reg.ref_s2;
    r_next.gtx_s1 = i_gtx_clk;
    r_next.gtx_s2 = r_reg.gtx_s1;
    r_next.gtx_s3 = r_reg.gtx_s2;
    // carrier sense pin is asynchronous: plain two-stage synchroniser
    r_next.crs_s1 = i_carrier_sense;
    r_next.crs_s2 = r_reg.crs_s1;
    // free-running 25 mhz source for phy emulation
    if (r_reg.div == 2'(`MMTX_MII_HALF - 1)) begin
      r_next.div     = 2'h0;
      r_next.gen_clk = !r_reg.gen_clk;
    end else begin
      r_next.div = r_reg.div + 2'h1;
    end
    // pins move only on the selected clock's rising edge
    if (launch) begin
      if (take) begin
        r_next.txd = i_sym_data[7:0] & lane_mask;
        if (i_mode == MMTX_MODE_TBI) begin
          r_next.txen = i_sym_data[`MMTX_BIT8_POS];
        end else begin
          r_next.txen = 1'b1;
        end
        r_next.st = i_sym_last ? MMTX_ST_TAIL : MMTX_ST_SEND;
      end else if (r_reg.st == MMTX_ST_SEND) begin
        // source gap inside a frame: send zeros; keep enable except in tbi, where the enable pin goes low
        r_next.txd  = `MMTX_TXD_RST;
        r_next.txen = (i_mode != MMTX_MODE_TBI);
      end else begin
        r_next.txd  = `MMTX_TXD_RST;
        r_next.txen = `MMTX_EN_RST;
        r_next.st   = MMTX_ST_IDLE;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      // all flops reset together, st to idle and the rest to zero; the oe outputs follow the role inputs directly
      r_reg <= '{txc_s1: 1'b0, txc_s2: 1'b0, txc_s3: 1'b0,
                 ref_s1: 1'b0, ref_s2: 1'b0, ref_s3: 1'b0,
                 gtx_s1: 1'b0, gtx_s2: 1'b0, gtx_s3: 1'b0,
                 crs_s1: 1'b0, crs_s2: 1'b0, div: 2'h0, gen_clk: 1'b0,
                 st: MMTX_ST_IDLE, txd: `MMTX_TXD_RST, txen: `MMTX_EN_RST};
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // pins
  always_comb begin
    o_txd              = r_reg.txd;
    o_tx_en            = r_reg.txen;
    o_tx_clk           = r_reg.gen_clk;
    // limitation: only mii has a clock output; other modes keep the pin undriven
    o_tx_clk_oe        = i_phy_role && (i_mode == MMTX_MODE_MII);
    o_carrier_sense    = (r_reg.st != MMTX_ST_IDLE);
    o_carrier_sense_oe = i_phy_role;
    o_carrier_seen     = r_reg.crs_s2;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  mii_lanes_a: assert property (
    take && i_mode == MMTX_MODE_MII |=> o_txd[7:4] == 4'h0)
    else $error("upper mii lanes not low");
  rmii_lanes_a: assert property (
    take && i_mode == MMTX_MODE_RMII
      |=> o_txd[7:2] == 6'h00 && o_txd[1:0] == $past(i_sym_data[1:0]))
    else $error("rmii lanes wrong");
  launch_edge_a: assert property (
    $changed(o_txd) |-> $past(launch))
    else $error("data changed away from a clock edge");
  en_first_a: assert property (
    take && r_reg.st == MMTX_ST_IDLE && i_mode != MMTX_MODE_TBI |=> o_tx_en)
    else $error("enable not raised with first symbol");
  en_hold_a: assert property (
    $fell(o_tx_en) && $past(i_mode) != MMTX_MODE_TBI
      |-> $past(launch) && $past(r_reg.st) != MMTX_ST_SEND)
    else $error("enable dropped inside frame");
  tbi_bit8_a: assert property (
    take && i_mode == MMTX_MODE_TBI |=> o_tx_en == $past(i_sym_data[8]))
    else $error("tbi bit 8 wrong");
  gen_period_a: assert property (
    $rose(o_tx_clk) |-> o_tx_clk ##1 o_tx_clk ##1 !o_tx_clk ##1 !o_tx_clk ##1 o_tx_clk)
    else $error("generated clock not 25 mhz");
  clk_dir_a: assert property (
    !i_phy_role |-> !o_tx_clk_oe)
    else $error("transmit clock driven in mac role");
  crs_out_a: assert property (
    i_phy_role && take |=> o_carrier_sense && o_carrier_sense_oe)
    else $error("carrier sense not driven while sending");

  // ==========================================================
  // data, hold and gap checks
  mii_data_a: assert property (
    take && i_mode == MMTX_MODE_MII |=> o_txd[3:0] == $past(i_sym_data[3:0]))
    else $error("mii data lanes wrong");

  wide_data_a: assert property (
    take && (i_mode == MMTX_MODE_GMII || i_mode == MMTX_MODE_TBI)
      |=> o_txd == $past(i_sym_data[7:0]))
    else $error("full-width data wrong");

  hold_off_a: assert property (
    !launch |=> $stable(o_txd) && $stable(o_tx_en))
    else $error("pins moved without a launch edge");

  phy_launch_a: assert property (
    i_phy_role && i_mode == MMTX_MODE_MII && o_sym_ready |=> $rose(o_tx_clk))
    else $error("data not launched with generated clock rise");

  ready_pulse_a: assert property (
    o_sym_ready ##1 ($stable(i_mode) && $stable(i_phy_role)) |-> !o_sym_ready)
    else $error("ready held past one launch");

  en_gap_a: assert property (
    launch && !take && r_reg.st == MMTX_ST_SEND && i_mode != MMTX_MODE_TBI |=> o_tx_en)
    else $error("enable dropped in a source gap");

  tail_drop_a: assert property (
    launch && r_reg.st == MMTX_ST_TAIL |=> !o_tx_en && o_txd == 8'h00)
    else $error("enable not dropped after last symbol");

  idle_quiet_a: assert property (
    r_reg.st == MMTX_ST_IDLE |-> o_txd == 8'h00 && !o_tx_en)
    else $error("pins not quiet between frames");

  // ==========================================================
  // scenario covers
  mii_frame_c: cover property (take && i_mode == MMTX_MODE_MII && i_sym_last);
  rmii_frame_c: cover property (take && i_mode == MMTX_MODE_RMII && i_sym_last);
  tbi_group_c: cover property (take && i_mode == MMTX_MODE_TBI);
  phy_role_c: cover property (i_phy_role && take && i_mode == MMTX_MODE_MII);
  gmii_frame_c: cover property (take && i_mode == MMTX_MODE_GMII && i_sym_last);

endmodule
`default_nettype wire

// ==== test/mmtx_link_partner.sv ====
// link partner model: makes the link clock and records the transmit pins
`timescale 1ns/1ps
`default_nettype none
module mmtx_link_partner (
  input  wire logic       i_run,
  input  wire logic       i_smp_clk,
  input  wire logic [7:0] i_txd,
  input  wire logic       i_tx_en,
  output logic            o_lclk
);
  logic [8:0] cap[$];
  initial o_lclk = 1'b0;
  // =====================================
  // link clock, stands still between frames
  always #40 o_lclk = i_run ? ~o_lclk : 1'b0;
  // sample on the far side's rising edge; idle zeros are not recorded
  always @(posedge i_smp_clk) begin
    if (i_tx_en || i_txd != 8'h00) begin
      cap.push_back({i_tx_en, i_txd});
    end
  end
endmodule
`default_nettype wire

// ==== test/multi_mode_mac_transmit_port_tb.sv ====
// testbench of the multi-mode transmit port
`timescale 1ns/1ps
`default_nettype none
module multi_mode_mac_transmit_port_tb;
  import mmtx_pkg::*;
  logic       i_mclk = 0, i_rstn = 0, i_phy_role = 0, i_carrier_sense = 0, run = 0;
  logic       i_sym_valid = 0, i_sym_last = 0;
  logic [8:0] i_sym_data = 9'h000;
  mmtx_mode_t i_mode = MMTX_MODE_MII;
  logic       o_tx_clk, o_tx_clk_oe, o_carrier_sense, o_carrier_sense_oe, o_carrier_seen;
  logic       o_sym_ready, o_tx_en, lclk;
  logic [7:0] o_txd;
  int         miscompares = 0, n_tests = 0;
  real        t0;
  always #5 i_mclk = ~i_mclk;
  mmtx_port mmtx_port_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_mode(i_mode),
    .i_phy_role(i_phy_role), .i_tx_clk(lclk), .o_tx_clk(o_tx_clk), .o_tx_clk_oe(o_tx_clk_oe),
    .i_ref_clk(lclk), .i_gtx_clk(lclk), .i_carrier_sense(i_carrier_sense),
    .o_carrier_sense(o_carrier_sense), .o_carrier_sense_oe(o_carrier_sense_oe),
    .o_carrier_seen(o_carrier_seen), .i_sym_valid(i_sym_valid), .i_sym_data(i_sym_data),
    .i_sym_last(i_sym_last), .o_sym_ready(o_sym_ready), .o_txd(o_txd), .o_tx_en(o_tx_en));
  // in phy emulation the far side samples on the falling edge of our clock
  mmtx_link_partner mmtx_link_partner_i (.i_run(run),
    .i_smp_clk(i_phy_role ? ~o_tx_clk : lclk), .i_txd(o_txd), .i_tx_en(o_tx_en), .o_lclk(lclk));
  // =====================================
  // reporting
  task check(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task test_done;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // =====================================
  // one frame of n symbols, then compare what the partner saw
  // outside tbi, a gap index of 1 to n-1 withholds valid for one launch before that symbol
  task wait_ready;
    int w;
    w = 0;
    while (o_sym_ready !== 1'b1 && w < 100) begin
      @(posedge i_mclk);
      #1;
      w++;
    end
    if (w >= 100) check("ready", 9'h001, 9'h000);
    // the edge after a settled ready is the one at which the design takes
    @(posedge i_mclk);
    #1;
  endtask
  task frame(input mmtx_mode_t m, input logic phy, input logic [8:0] base, input int n,
             input int gap);
    logic [7:0] mask;
    logic [8:0] d;
    int         g;
    mask = (m == MMTX_MODE_MII) ? 8'h0F : (m == MMTX_MODE_RMII) ? 8'h03 : 8'hFF;
    g = (gap > 0 && gap < n && m != MMTX_MODE_TBI) ? 1 : 0;
    i_mode = m;
    i_phy_role = phy;
    run = 1'b1;
    mmtx_link_partner_i.cap.delete();
    @(posedge i_mclk);
    #1;
    check("clk oe", {8'h00, phy && m == MMTX_MODE_MII}, {8'h00, o_tx_clk_oe});
    check("crs oe", {8'h00, phy}, {8'h00, o_carrier_sense_oe});
    for (int k = 0; k < n; k++) begin
      if (g == 1 && k == gap) begin
        i_sym_valid = 1'b0;
        wait_ready();
      end
      i_sym_valid = 1'b1;
      i_sym_data = base + 9'(k * 37);
      i_sym_last = (k == n - 1);
      wait_ready();
      if (k == 0) check("crs out", 9'h001, {8'h00, o_carrier_sense});
    end
    i_sym_valid = 1'b0;
    i_sym_last = 1'b0;
    repeat (30) @(posedge i_mclk);
    #1;
    check("crs idle", 9'h000, {8'h00, o_carrier_sense});
    check("count", 9'(n + g), 9'(mmtx_link_partner_i.cap.size()));
    for (int k = 0; k < n; k++) begin
      d = base + 9'(k * 37);
      check("symbol", (m == MMTX_MODE_TBI) ? d : {1'b1, d[7:0] & mask},
            mmtx_link_partner_i.cap[k + ((g == 1 && k >= gap) ? 1 : 0)]);
    end
    if (g == 1) check("gap", 9'h100, mmtx_link_partner_i.cap[gap]);
    run = 1'b0;
  endtask
  task phy_clock;
    @(posedge o_tx_clk);
    t0 = $realtime;
    @(posedge o_tx_clk);
    check("clk period", 9'h028, 9'(int'($realtime - t0)));
    #1;
  endtask
  task carrier;
    i_carrier_sense = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1;
    check("crs seen", 9'h001, {8'h00, o_carrier_seen});
    i_carrier_sense = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    check("crs clear", 9'h000, {8'h00, o_carrier_seen});
  endtask
  // =====================================
  initial begin
    repeat (10) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    frame(MMTX_MODE_MII, 1'b0, 9'h0A5, 3, -1);
    frame(MMTX_MODE_RMII, 1'b0, 9'h0B6, 4, -1);
    frame(MMTX_MODE_RMII, 1'b0, 9'h0D2, 3, 1);
    frame(MMTX_MODE_GMII, 1'b0, 9'h0C3, 3, -1);
    frame(MMTX_MODE_TBI, 1'b0, 9'h1E7, 4, -1);
    frame(MMTX_MODE_MII, 1'b1, 9'h05A, 3, -1);
    phy_clock();
    carrier();
    test_done();
  end
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
